// ===== src/adc_cfg_consts.svh
// Purpose: Offsets, field positions, masks and reset values of the
//          converter configuration block.
// Assumes: Byte addresses on an 8-bit AXI4-Lite address.
// Notes:   Definitions only.
`ifndef ADC_CFG_CONSTS_SVH
`define ADC_CFG_CONSTS_SVH

`define ADDR_W 8
`define OFF_CON1 8'h00
`define OFF_CON2 8'h04
`define OFF_CON3 8'h08
`define OFF_CHS 8'h0c
`define OFF_PCFG 8'h10
`define OFF_SCAN 8'h14
`define OFF_PORT 8'h18
`define RESULT_PAGE 2'h1

`define CON1_ON_BIT 15
`define RESULT_FORMAT_HI 10
`define RESULT_FORMAT_LO 8
`define TRIGGER_SOURCE_SELECT_HI 7
`define TRIGGER_SOURCE_SELECT_LO 5
`define REFERENCE_SELECT_HI 15
`define REFERENCE_SELECT_LO 13
`define SCAN_ENABLE_BIT 10
`define SMPI_HI 5
`define SMPI_LO 2
`define BUFFER_FILL_MODE_BIT 1
`define ALTERNATE_MUX_SELECT_BIT 0
`define CONV_CLOCK_SOURCE_BIT 15
`define AUTO_SAMPLE_TIME_HI 12
`define AUTO_SAMPLE_TIME_LO 8
`define CONV_CLOCK_PRESCALE_HI 7
`define CONV_CLOCK_PRESCALE_LO 0
`define CHNB_BIT 31
`define CHSB_HI 27
`define CHSB_LO 24
`define CHNA_BIT 23
`define CHSA_HI 19
`define CHSA_LO 16

`define CON1_MASK 16'h87e0
`define CON2_MASK 16'he43f
`define CON3_MASK 16'h9fff
`define CHS_MASK 32'h8f8f0000
`define CON_RST 16'h0000
`define CHS_RST 32'h00000000
`define PCFG_RST 16'h0000
`define SCAN_RST 16'h0000

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== src/adc_cfg_pkg.sv
// Purpose: Types shared by the converter configuration block.
// Assumes: Nothing beyond the constants header.
// Notes:   Every module state is one packed struct.
package adc_cfg_pkg;

	typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} rd_state_type;

	typedef enum logic [1:0] {
		FMT_INTEGER,
		FMT_SIGNED_INT,
		FMT_FRACTION,
		FMT_SIGNED_FRACTION
	} format_kind_type;

	typedef struct packed {
		logic [15:0][9:0] words;
		logic [9:0] rd_data;
	} store_state_type;

	typedef struct packed {
		logic [15:0] con1;
		logic [15:0] con2;
		logic [15:0] con3;
		logic [31:0] chs;
		logic [15:0] pcfg;
		logic [15:0] scan;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		rd_state_type rd_state;
		logic [7:0] rd_addr;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic alt_phase;
	} top_state_type;

endpackage

// ===== src/result_store.sv
// Purpose: Sixteen-word store of raw 10-bit conversion codes.
// Assumes: One write and one read port, both on the system clock.
// Notes:   Read data appear one cycle after rd_en, from a register.
module result_store
	import adc_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire logic [9:0] wr_data,
	input wire logic rd_en,
	input wire logic [3:0] rd_addr,
	output logic [9:0] rd_data
);

	store_state_type s_reg;
	store_state_type s_next;

	always_comb begin
		s_next = s_reg;
		if (wr_en) begin
			s_next.words[wr_addr] = wr_data;
		end
		if (rd_en) begin
			s_next.rd_data = s_reg.words[rd_addr];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rd_data = s_reg.rd_data;

endmodule // result_store

// ===== src/result_formatter.sv
// Purpose: Turns a raw 10-bit code into one of seven read formats, chosen by eight format codes.
// Assumes: Format field is width bit on top, kind in the two low bits.
// Notes:   Purely combinational; the caller registers the result.
module result_formatter
	import adc_cfg_pkg::*;
(
	input wire logic [9:0] code,
	input wire logic [2:0] format,
	output logic [31:0] value
);

	logic sgn;
	logic wide;
	format_kind_type kind;

	always_comb begin
		sgn = ~code[9];
		wide = format[2];
		kind = format_kind_type'(format[1:0]);
		value = 32'h00000000;
		case (kind)
			FMT_INTEGER: begin
				value = {22'h000000, code};
			end
			FMT_SIGNED_INT: begin
				if (wide) begin
					value = {{22{sgn}}, sgn, code[8:0]};
				end else begin
					value = {16'h0000, {6{sgn}}, sgn, code[8:0]};
				end
			end
			FMT_FRACTION: begin
				if (wide) begin
					value = {code, 22'h000000};
				end else begin
					value = {16'h0000, code, 6'h00};
				end
			end
			FMT_SIGNED_FRACTION: begin
				if (wide) begin
					value = {sgn, code[8:0], 22'h000000};
				end else begin
					value = {16'h0000, sgn, code[8:0], 6'h00};
				end
			end
			default: begin
				value = 32'h00000000;
			end
		endcase
	end

endmodule // result_formatter

// ===== src/adc_config_regs.sv
// Purpose: Configuration registers, input selection and result reads of
//          a 10-bit successive-approximation converter.
// Assumes: AXI4-Lite slave on SYS_CLK, one write and one read at a time.
// Notes:   Result codes are stored raw and formatted on every read.
`include "adc_cfg_consts.svh"

module adc_config_regs
	import adc_cfg_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [7:0] AWADDR,
	input wire logic [2:0] AWPROT,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [7:0] ARADDR,
	input wire logic [2:0] ARPROT,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	input wire logic RESULT_WRITE,
	input wire logic [3:0] RESULT_INDEX,
	input wire logic [9:0] RESULT_CODE,
	input wire logic [3:0] SCAN_CHANNEL,
	input wire logic [15:0] PORT_PINS,
	output logic [15:0] DIGITAL_INPUT_ENABLE,
	output logic [3:0] MUX_POS_SELECT,
	output logic MUX_NEG_SELECT,
	output logic MUX_B_ACTIVE,
	output logic MODULE_ON,
	output logic [2:0] RESULT_FORMAT,
	output logic [2:0] TRIGGER_SOURCE_SELECT,
	output logic [2:0] REFERENCE_SELECT,
	output logic SCAN_ENABLE,
	output logic [15:0] SCAN_CHANNEL_MASK,
	output logic [3:0] CONVERSIONS_PER_IRQ,
	output logic BUFFER_FILL_MODE,
	output logic ALTERNATE_MUX_SELECT,
	output logic CONV_CLOCK_SOURCE,
	output logic [4:0] AUTO_SAMPLE_TIME,
	output logic [7:0] CONV_CLOCK_PRESCALE
);

	////////////////////////////////////////////////////////////////////////

	function automatic logic is_mapped(input logic [7:0] addr);
		logic hit;
		hit = (addr == `OFF_CON1) || (addr == `OFF_CON2) ||
			(addr == `OFF_CON3) || (addr == `OFF_CHS) ||
			(addr == `OFF_PCFG) || (addr == `OFF_SCAN) ||
			(addr == `OFF_PORT) ||
			((addr[7:6] == `RESULT_PAGE) && (addr[1:0] == 2'h0));
		return hit;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////

	top_state_type s_reg;
	top_state_type s_next;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	logic [31:0] merged;
	logic [9:0] store_code;
	logic [31:0] formatted;
	logic [3:0] mux_a_pos_select;
	logic mux_a_neg_select;
	logic [3:0] mux_b_pos_select;
	logic mux_b_neg_select;

	assign aw_take = AWVALID && !s_reg.aw_held && !s_reg.bvalid;
	assign w_take = WVALID && !s_reg.w_held && !s_reg.bvalid;
	assign ar_take = ARVALID && (s_reg.rd_state == RD_IDLE);

	result_store store (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.wr_en(RESULT_WRITE),
		.wr_addr(RESULT_INDEX),
		.wr_data(RESULT_CODE),
		.rd_en(ar_take),
		.rd_addr(ARADDR[5:2]),
		.rd_data(store_code)
	);

	result_formatter formatter (
		.code(store_code),
		.format(s_reg.con1[`RESULT_FORMAT_HI:`RESULT_FORMAT_LO]),
		.value(formatted)
	);

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		s_next = s_reg;
		wa = s_reg.aw_held ? s_reg.aw_addr : AWADDR;
		wd = s_reg.w_held ? s_reg.w_data : WDATA;
		ws = s_reg.w_held ? s_reg.w_strb : WSTRB;
		merged = 32'h00000000;

		// Write path: address and data may arrive in either order
		if ((s_reg.aw_held || aw_take) && (s_reg.w_held || w_take)) begin
			case (wa)
				`OFF_CON1: begin
					merged = merge({16'h0000, s_reg.con1}, wd, ws);
					s_next.con1 = merged[15:0] & `CON1_MASK;
				end
				`OFF_CON2: begin
					merged = merge({16'h0000, s_reg.con2}, wd, ws);
					s_next.con2 = merged[15:0] & `CON2_MASK;
				end
				`OFF_CON3: begin
					merged = merge({16'h0000, s_reg.con3}, wd, ws);
					s_next.con3 = merged[15:0] & `CON3_MASK;
				end
				`OFF_CHS: begin
					s_next.chs = merge(s_reg.chs, wd, ws) & `CHS_MASK;
				end
				`OFF_PCFG: begin
					merged = merge({16'h0000, s_reg.pcfg}, wd, ws);
					s_next.pcfg = merged[15:0];
				end
				`OFF_SCAN: begin
					merged = merge({16'h0000, s_reg.scan}, wd, ws);
					s_next.scan = merged[15:0];
				end
				default: begin
					s_next.scan = s_reg.scan;
				end
			endcase
			s_next.aw_held = 1'b0;
			s_next.w_held = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = is_mapped(wa) ? `RESP_OKAY : `RESP_SLVERR;
		end else begin
			if (aw_take) begin
				s_next.aw_held = 1'b1;
				s_next.aw_addr = AWADDR;
			end
			if (w_take) begin
				s_next.w_held = 1'b1;
				s_next.w_data = WDATA;
				s_next.w_strb = WSTRB;
			end
		end
		if (s_reg.bvalid && BREADY) begin
			s_next.bvalid = 1'b0;
		end

		// Read path: one cycle to fetch the store, then the answer
		case (s_reg.rd_state)
			RD_IDLE: begin
				if (ar_take) begin
					s_next.rd_addr = ARADDR;
					s_next.rd_state = RD_FETCH;
				end
			end
			RD_FETCH: begin
				s_next.rresp = is_mapped(s_reg.rd_addr) ? `RESP_OKAY :
					`RESP_SLVERR;
				s_next.rdata = 32'h00000000;
				if (s_reg.rd_addr[7:6] == `RESULT_PAGE) begin
					s_next.rdata = is_mapped(s_reg.rd_addr) ?
						formatted : 32'h00000000;
				end else begin
					case (s_reg.rd_addr)
						`OFF_CON1: s_next.rdata = {16'h0000, s_reg.con1};
						`OFF_CON2: s_next.rdata = {16'h0000, s_reg.con2};
						`OFF_CON3: s_next.rdata = {16'h0000, s_reg.con3};
						`OFF_CHS: s_next.rdata = s_reg.chs;
						`OFF_PCFG: s_next.rdata = {16'h0000, s_reg.pcfg};
						`OFF_SCAN: s_next.rdata = {16'h0000, s_reg.scan};
						`OFF_PORT: begin
							s_next.rdata = {16'h0000,
								PORT_PINS & s_reg.pcfg};
						end
						default: s_next.rdata = 32'h00000000;
					endcase
				end
				s_next.rd_state = RD_RESP;
			end
			RD_RESP: begin
				if (RREADY) begin
					s_next.rd_state = RD_IDLE;
				end
			end
			default: begin
				s_next.rd_state = RD_IDLE;
			end
		endcase

		// Alternate phase flips on every stored conversion while ALTERNATE_MUX_SELECT and the on bit are set, else clears
		if (!s_reg.con2[`ALTERNATE_MUX_SELECT_BIT] || !s_reg.con1[`CON1_ON_BIT]) begin
			s_next.alt_phase = 1'b0;
		end else if (RESULT_WRITE) begin
			s_next.alt_phase = ~s_reg.alt_phase;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s_reg <= '0;
			s_reg.con1 <= `CON_RST;
			s_reg.con2 <= `CON_RST;
			s_reg.con3 <= `CON_RST;
			s_reg.chs <= `CHS_RST;
			s_reg.pcfg <= `PCFG_RST;
			s_reg.scan <= `SCAN_RST;
			s_reg.rd_state <= RD_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input multiplexer selection

	always_comb begin
		mux_a_pos_select = s_reg.chs[`CHSA_HI:`CHSA_LO];
		if (s_reg.con2[`SCAN_ENABLE_BIT]) begin
			mux_a_pos_select = SCAN_CHANNEL;
		end
		mux_a_neg_select = s_reg.chs[`CHNA_BIT];
		mux_b_pos_select = s_reg.chs[`CHSB_HI:`CHSB_LO];
		mux_b_neg_select = s_reg.chs[`CHNB_BIT];
	end

	// Negative select: 1 is input one, 0 is the negative reference
	assign MUX_POS_SELECT = s_reg.alt_phase ? mux_b_pos_select :
		mux_a_pos_select;
	assign MUX_NEG_SELECT = s_reg.alt_phase ? mux_b_neg_select :
		mux_a_neg_select;
	assign MUX_B_ACTIVE = s_reg.alt_phase;
	assign DIGITAL_INPUT_ENABLE = s_reg.pcfg;

	////////////////////////////////////////////////////////////////////////
	// Bus handshakes and configuration fields

	assign AWREADY = !s_reg.aw_held && !s_reg.bvalid;
	assign WREADY = !s_reg.w_held && !s_reg.bvalid;
	assign BVALID = s_reg.bvalid;
	assign BRESP = s_reg.bresp;
	assign ARREADY = (s_reg.rd_state == RD_IDLE);
	assign RVALID = (s_reg.rd_state == RD_RESP);
	assign RDATA = s_reg.rdata;
	assign RRESP = s_reg.rresp;

	assign MODULE_ON = s_reg.con1[`CON1_ON_BIT];
	assign RESULT_FORMAT = s_reg.con1[`RESULT_FORMAT_HI:`RESULT_FORMAT_LO];
	assign TRIGGER_SOURCE_SELECT = s_reg.con1[`TRIGGER_SOURCE_SELECT_HI:`TRIGGER_SOURCE_SELECT_LO];
	assign REFERENCE_SELECT = s_reg.con2[`REFERENCE_SELECT_HI:`REFERENCE_SELECT_LO];
	assign SCAN_ENABLE = s_reg.con2[`SCAN_ENABLE_BIT];
	assign SCAN_CHANNEL_MASK = s_reg.scan;
	assign CONVERSIONS_PER_IRQ = s_reg.con2[`SMPI_HI:`SMPI_LO];
	assign BUFFER_FILL_MODE = s_reg.con2[`BUFFER_FILL_MODE_BIT];
	assign ALTERNATE_MUX_SELECT = s_reg.con2[`ALTERNATE_MUX_SELECT_BIT];
	assign CONV_CLOCK_SOURCE = s_reg.con3[`CONV_CLOCK_SOURCE_BIT];
	assign AUTO_SAMPLE_TIME = s_reg.con3[`AUTO_SAMPLE_TIME_HI:`AUTO_SAMPLE_TIME_LO];
	assign CONV_CLOCK_PRESCALE = s_reg.con3[`CONV_CLOCK_PRESCALE_HI:`CONV_CLOCK_PRESCALE_LO];

endmodule // adc_config_regs

// ===== test/adc_config_assertions.sv
// Purpose: Port-level checker for the converter configuration block.
// Assumes: Read address is stable while a read response is pending.
// Notes:   Attached to the top module by bind.
`include "adc_cfg_consts.svh"
module adc_config_checker (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [7:0] ARADDR,
	input wire logic RVALID,
	input wire logic [31:0] RDATA,
	input wire logic RESULT_WRITE,
	input wire logic [3:0] SCAN_CHANNEL,
	input wire logic [15:0] DIGITAL_INPUT_ENABLE,
	input wire logic [3:0] MUX_POS_SELECT,
	input wire logic MUX_B_ACTIVE,
	input wire logic MODULE_ON,
	input wire logic [2:0] RESULT_FORMAT,
	input wire logic SCAN_ENABLE,
	input wire logic ALTERNATE_MUX_SELECT
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rd_addr_reg;
	logic res_rd;
	logic alt_on;
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST)
			rd_addr_reg <= 8'h00;
		else if (ARVALID && ARREADY)
			rd_addr_reg <= ARADDR;
	end
	assign res_rd = RVALID && rd_addr_reg[7:6] == `RESULT_PAGE;
	assign alt_on = ALTERNATE_MUX_SELECT && MODULE_ON;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	////////////////////////////////////////
	property p_reset_analog;
		$fell(SYS_RST) |-> DIGITAL_INPUT_ENABLE == 16'h0000;
	endproperty
	a_reset_analog: assert property (p_reset_analog) else $error("pins not analog after reset");
	property p_scan_override;
		SCAN_ENABLE && !MUX_B_ACTIVE |-> MUX_POS_SELECT == SCAN_CHANNEL;
	endproperty
	a_scan_override: assert property (p_scan_override) else $error("scan channel not used");
	property p_alt_idle;
		!alt_on [*2] |-> !MUX_B_ACTIVE;
	endproperty
	a_alt_idle: assert property (p_alt_idle) else $error("mux B active while alternation off");
	property p_alt_toggle;
		alt_on && RESULT_WRITE ##1 alt_on |-> MUX_B_ACTIVE != $past(MUX_B_ACTIVE);
	endproperty
	a_alt_toggle: assert property (p_alt_toggle) else $error("mux phase did not swap");
	property p_alt_hold;
		alt_on && !RESULT_WRITE ##1 alt_on |-> $stable(MUX_B_ACTIVE);
	endproperty
	a_alt_hold: assert property (p_alt_hold) else $error("mux phase swapped without conversion");
	property p_port_analog;
		RVALID && rd_addr_reg == `OFF_PORT |-> (RDATA[15:0] & ~DIGITAL_INPUT_ENABLE) == 16'h0000;
	endproperty
	a_port_analog: assert property (p_port_analog) else $error("analog pin read as one");
	property p_upper_zero;
		res_rd && !RESULT_FORMAT[2] |-> RDATA[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper half set in 16-bit format");
	property p_int_fill;
		res_rd && RESULT_FORMAT[1:0] == 2'h0 |-> RDATA[31:10] == 22'h000000;
	endproperty
	a_int_fill: assert property (p_int_fill) else $error("integer result not zero-filled");
	property p_frac_low;
		res_rd && RESULT_FORMAT[1] |-> RDATA[5:0] == 6'h00;
	endproperty
	a_frac_low: assert property (p_frac_low) else $error("fraction low bits not zero");
	c_wide_read: cover property (res_rd && RESULT_FORMAT[2]);
	c_alt_swap: cover property (alt_on && RESULT_WRITE);
	c_scan_on: cover property (SCAN_ENABLE && !MUX_B_ACTIVE);
endmodule // adc_config_checker

bind adc_config_regs adc_config_checker u_chk (.SYS_CLK(SYS_CLK),
	.SYS_RST(SYS_RST), .ARVALID(ARVALID), .ARREADY(ARREADY),
	.ARADDR(ARADDR), .RVALID(RVALID), .RDATA(RDATA),
	.RESULT_WRITE(RESULT_WRITE), .SCAN_CHANNEL(SCAN_CHANNEL),
	.DIGITAL_INPUT_ENABLE(DIGITAL_INPUT_ENABLE),
	.MUX_POS_SELECT(MUX_POS_SELECT), .MUX_B_ACTIVE(MUX_B_ACTIVE),
	.MODULE_ON(MODULE_ON), .RESULT_FORMAT(RESULT_FORMAT),
	.SCAN_ENABLE(SCAN_ENABLE), .ALTERNATE_MUX_SELECT(ALTERNATE_MUX_SELECT));

// ===== test/tb_top.sv
// Purpose: Self-checking bench for the converter configuration block.
// Assumes: AXI4-Lite master samples handshakes mid-cycle.
// Notes:   Expected responses queue up; a monitor compares them.
`include "adc_cfg_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic SYS_CLK, SYS_RST, AWVALID, AWREADY, WVALID, WREADY, BVALID;
	logic BREADY, ARVALID, ARREADY, RVALID, RREADY, RESULT_WRITE;
	logic [7:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [1:0] BRESP, RRESP;
	logic [3:0] RESULT_INDEX, SCAN_CHANNEL, MUX_POS_SELECT, CONVERSIONS_PER_IRQ;
	logic [3:0] WSTRB;
	logic [9:0] RESULT_CODE;
	logic [15:0] PORT_PINS, DIGITAL_INPUT_ENABLE, SCAN_CHANNEL_MASK;
	logic MUX_NEG_SELECT, MUX_B_ACTIVE, MODULE_ON, SCAN_ENABLE;
	logic BUFFER_FILL_MODE, ALTERNATE_MUX_SELECT, CONV_CLOCK_SOURCE;
	logic [2:0] RESULT_FORMAT, TRIGGER_SOURCE_SELECT, REFERENCE_SELECT;
	logic [4:0] AUTO_SAMPLE_TIME;
	logic [7:0] CONV_CLOCK_PRESCALE;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [9:0] codes[6];
	logic [15:0] p, q;
	logic [31:0] c;
	int err_count, comparisons, cyc;
	adc_config_regs uut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .AWPROT(3'h0),
		.WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID),
		.RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
		.RESULT_WRITE(RESULT_WRITE), .RESULT_INDEX(RESULT_INDEX),
		.RESULT_CODE(RESULT_CODE), .SCAN_CHANNEL(SCAN_CHANNEL),
		.PORT_PINS(PORT_PINS), .DIGITAL_INPUT_ENABLE(DIGITAL_INPUT_ENABLE),
		.MUX_POS_SELECT(MUX_POS_SELECT), .MUX_NEG_SELECT(MUX_NEG_SELECT),
		.MUX_B_ACTIVE(MUX_B_ACTIVE), .MODULE_ON(MODULE_ON),
		.RESULT_FORMAT(RESULT_FORMAT),
		.TRIGGER_SOURCE_SELECT(TRIGGER_SOURCE_SELECT),
		.REFERENCE_SELECT(REFERENCE_SELECT), .SCAN_ENABLE(SCAN_ENABLE),
		.SCAN_CHANNEL_MASK(SCAN_CHANNEL_MASK),
		.CONVERSIONS_PER_IRQ(CONVERSIONS_PER_IRQ),
		.BUFFER_FILL_MODE(BUFFER_FILL_MODE),
		.ALTERNATE_MUX_SELECT(ALTERNATE_MUX_SELECT),
		.CONV_CLOCK_SOURCE(CONV_CLOCK_SOURCE),
		.AUTO_SAMPLE_TIME(AUTO_SAMPLE_TIME),
		.CONV_CLOCK_PRESCALE(CONV_CLOCK_PRESCALE));
	always #2 SYS_CLK = ~SYS_CLK;
	////////////////////////////////////////
	function automatic logic [31:0] exp_fmt(input logic [9:0] k,
			input logic [2:0] f);
		logic [9:0] s;
		logic [31:0] v;
		s = {~k[9], k[8:0]};
		case (f[1:0])
			2'h0: v = {22'h0, k};
			2'h1: v = {{22{s[9]}}, s};
			2'h2: v = {k, 22'h0};
			default: v = {s, 22'h0};
		endcase
		if (!f[2])
			v = f[1] ? {16'h0, v[31:16]} : {16'h0, v[15:0]};
		return v;
	endfunction
	task automatic check(input logic [33:0] g, input logic [33:0] e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic test_done;
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] r);
		logic ap, wp, ta, tw;
		ap = 1'b1;
		wp = 1'b1;
		bq.push_back(r);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		while (ap || wp) begin
			@(negedge SYS_CLK);
			ta = ap && AWREADY;
			tw = wp && WREADY;
			@(posedge SYS_CLK);
			if (ta)
				AWVALID <= 1'b0;
			if (tw)
				WVALID <= 1'b0;
			ap = ap && !ta;
			wp = wp && !tw;
		end
		BREADY <= 1'b1;
		ta = 1'b0;
		while (!ta) begin
			@(negedge SYS_CLK);
			ta = BVALID;
			@(posedge SYS_CLK);
		end
		BREADY <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		logic t;
		rq.push_back(e);
		ARADDR <= a;
		ARVALID <= 1'b1;
		t = 1'b0;
		while (!t) begin
			@(negedge SYS_CLK);
			t = ARREADY;
			@(posedge SYS_CLK);
		end
		ARVALID <= 1'b0;
		RREADY <= 1'b1;
		t = 1'b0;
		while (!t) begin
			@(negedge SYS_CLK);
			t = RVALID;
			@(posedge SYS_CLK);
		end
		RREADY <= 1'b0;
	endtask
	task automatic put(input logic [3:0] i, input logic [9:0] k);
		RESULT_WRITE <= 1'b1;
		RESULT_INDEX <= i;
		RESULT_CODE <= k;
		@(posedge SYS_CLK);
		RESULT_WRITE <= 1'b0;
		@(posedge SYS_CLK);
	endtask
	always @(posedge SYS_CLK) begin
		if (RVALID && RREADY)
			check({RRESP, RDATA}, rq.pop_front());
		if (BVALID && BREADY)
			check({32'h0, BRESP}, {32'h0, bq.pop_front()});
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		{SYS_CLK, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
		{RESULT_WRITE, RESULT_INDEX, RESULT_CODE, SCAN_CHANNEL} = '0;
		{AWADDR, ARADDR, WDATA, PORT_PINS} = '0;
		WSTRB = 4'hf;
		SYS_RST = 1'b1;
		void'($urandom(32'haf59));
		codes = '{10'h000, 10'h001, 10'h1ff, 10'h200, 10'h3ff, 10'h155};
		repeat (10) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		@(posedge SYS_CLK);
		rd(`OFF_PCFG, 34'h0);
		rd(`OFF_CON1, 34'h0);
		check(DIGITAL_INPUT_ENABLE, 34'h0);
		$display("test 1 done");
		p = 16'($urandom);
		q = 16'($urandom);
		PORT_PINS <= q;
		wr(`OFF_PCFG, {16'h0, p}, `RESP_OKAY);
		@(negedge SYS_CLK);
		check(DIGITAL_INPUT_ENABLE, {18'h0, p});
		@(posedge SYS_CLK);
		rd(`OFF_PORT, {18'h0, q & p});
		$display("test 2 done");
		codes[5] = 10'($urandom);
		for (int i = 0; i < 6; i++)
			put(4'(i), codes[i]);
		for (int f = 0; f < 8; f++) begin
			wr(`OFF_CON1, {21'h0, 3'(f), 8'h00}, `RESP_OKAY);
			for (int i = 0; i < 6; i++)
				rd(8'(8'h40 + 4 * i), {2'h0, exp_fmt(codes[i], 3'(f))});
		end
		$display("test 3 done");
		p = 16'($urandom) & 16'h7bff;
		wr(`OFF_CON1, {16'h0, p}, `RESP_OKAY);
		@(negedge SYS_CLK);
		check({MODULE_ON, RESULT_FORMAT, TRIGGER_SOURCE_SELECT}, {p[15], p[10:8], p[7:5]});
		p = 16'($urandom) & 16'hfbff;
		@(posedge SYS_CLK);
		wr(`OFF_CON2, {16'h0, p}, `RESP_OKAY);
		@(negedge SYS_CLK);
		check({REFERENCE_SELECT, SCAN_ENABLE, CONVERSIONS_PER_IRQ, BUFFER_FILL_MODE, ALTERNATE_MUX_SELECT}, {p[15:13], p[10], p[5:0]});
		p = 16'($urandom);
		@(posedge SYS_CLK);
		wr(`OFF_CON3, {16'h0, p}, `RESP_OKAY);
		@(negedge SYS_CLK);
		check({CONV_CLOCK_SOURCE, AUTO_SAMPLE_TIME, CONV_CLOCK_PRESCALE}, {p[15], p[12:0]});
		c = $urandom;
		@(posedge SYS_CLK);
		wr(`OFF_CHS, c, `RESP_OKAY);
		@(negedge SYS_CLK);
		check({MUX_B_ACTIVE, MUX_POS_SELECT, MUX_NEG_SELECT}, {1'b0, c[19:16], c[23]});
		@(posedge SYS_CLK);
		rd(`OFF_CHS, {2'h0, c & `CHS_MASK});
		rd(`OFF_CON3, {18'h0, p & `CON3_MASK});
		$display("test 4 done");
		SCAN_CHANNEL <= 4'($urandom);
		wr(`OFF_CON2, 32'h00000401, `RESP_OKAY);
		wr(`OFF_CON1, 32'h00008000, `RESP_OKAY);
		@(negedge SYS_CLK);
		check({MUX_B_ACTIVE, MUX_POS_SELECT, MUX_NEG_SELECT}, {1'b0, SCAN_CHANNEL, c[23]});
		@(posedge SYS_CLK);
		put(4'h0, 10'h2aa);
		@(negedge SYS_CLK);
		check({MUX_B_ACTIVE, MUX_POS_SELECT, MUX_NEG_SELECT}, {1'b1, c[27:24], c[31]});
		@(posedge SYS_CLK);
		put(4'h1, 10'h055);
		@(negedge SYS_CLK);
		check(MUX_B_ACTIVE, 34'h0);
		@(posedge SYS_CLK);
		$display("test 5 done");
		rd(8'h1c, {`RESP_SLVERR, 32'h0});
		rd(8'h80, {`RESP_SLVERR, 32'h0});
		wr(8'h1c, 32'hffffffff, `RESP_SLVERR);
		wr(`OFF_PORT, 32'hffffffff, `RESP_OKAY);
		WSTRB <= 4'h1;
		wr(`OFF_SCAN, 32'hffffffff, `RESP_OKAY);
		WSTRB <= 4'hf;
		@(negedge SYS_CLK);
		check(SCAN_CHANNEL_MASK, 34'h00ff);
		@(posedge SYS_CLK);
		rd(`OFF_SCAN, 34'h00ff);
		$display("test 6 done");
		test_done();
	end
endmodule // tb_top
